/* src/dmaq_pkg.sv */
package dmaq_pkg;
  localparam int          DMAQ_NCH      = 8;
  localparam int          DMAQ_CNT_W    = 24;
  // Register byte offsets
  localparam logic [11:0] OFF_OPER      = 12'h000;
  localparam logic [11:0] OFF_EVT       = 12'h004;
  localparam logic [4:0]  CH_REGION     = 5'h02;
  localparam logic [1:0]  CH_SAR        = 2'h0;
  localparam logic [1:0]  CH_DAR        = 2'h1;
  localparam logic [1:0]  CH_TCR        = 2'h2;
  localparam logic [1:0]  CH_CTRL       = 2'h3;
  // Field positions
  localparam int          OPER_DME      = 0;
  localparam int          OPER_NMI_FLAG     = 1;
  localparam int          OPER_AE       = 2;
  localparam int          OPER_SEL8     = 14;
  localparam int          OPER_ODT      = 15;
  localparam int          CTRL_DE       = 0;
  localparam int          CTRL_TE       = 1;
  localparam int          CTRL_IE       = 2;
  localparam int          CTRL_SAM      = 3;
  // Request word decode values
  localparam logic [1:0]  RQ_ID_CLR     = 2'h0;
  localparam logic [1:0]  RQ_MD_ALL     = 2'h2;
  localparam logic [1:0]  RQ_MD_ONE     = 2'h3;
  localparam logic [2:0]  RQ_SZ_ALL     = 3'h6;
  localparam logic [2:0]  RQ_SZ_HI      = 3'h5;
  localparam logic [7:0]  PERIPH_TOP    = 8'hFF;
  // Event codes, channel 0 first, address error last
  localparam logic [11:0] EVT_CODE [DMAQ_NCH] = '{12'h640, 12'h660, 12'h680, 12'h6A0,
                                                 12'h780, 12'h7A0, 12'h7C0, 12'h7E0};
  localparam logic [11:0] EVT_AE        = 12'h6C0;
  localparam logic [31:0] ADDR_STEP     = 32'h0000_0004;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Timing
  localparam int          CLK_NS        = 20;
  localparam int          BUS_NS        = 80;
  localparam int          BUS_CYC       = (BUS_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [2:0]  size;
    logic        rsv;
    logic [1:0]  chan_id;
    logic [1:0]  mode;
    logic [3:0]  count_hi;
    logic [19:0] rest;
  } dmaq_req_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} dmaq_state_t;
endpackage : dmaq_pkg

/* src/dmaq_ctrl.sv */
// Contract
// - Decode special request words as queue clears
// - Per-channel clear needs eight-channel select set
// - ID00 MD10 SZ110 clears queues 1-7, ch0 flag
// - Mode 11 nibble 0001 clears ch0 flag
// - Nibbles 0010..1000 clear channel 1..7 queue
// - Size 31:29, ID 27:26, mode 25:24, nibble 23:20
// - Count done with irq enable raises irq
// - Fixed event codes, channel 0 highest priority
// - NMI input always sets nmi flag
// - NMI stops new transfers, count and addresses held after current bus cycle
// - Master disable stops after current bus cycle
// - Run needs master and channel enable
// - Single-address peripheral target flags address error
// - Address error halts all, clear by read-then-zero
`timescale 1ns/100ps
`default_nettype none
module dmaq_ctrl
  import dmaq_pkg::*;
#(
  parameter int NCH   = dmaq_pkg::DMAQ_NCH,
  parameter int QMAX  = 3
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // On-demand request words
  input  wire logic                 req_valid,
  input  wire dmaq_pkg::dmaq_req_t  req_word,
  output logic                      req_ready,
  // Non-maskable interrupt, one-cycle pulse
  input  wire logic                 nmi_in,
  // Transfer side
  output logic                      transfer_ack,
  output logic [2:0]                ack_channel,
  output logic [31:0]               bus_addr,
  // Interrupt request
  output logic                      irq,
  output logic [11:0]               irq_code
);
  import dmaq_pkg::*;

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic                  master_enable_bit, nmi_flag, ae, sel8, odt, ae_arm, nmi_flag_arm;
  logic [31:0]           source_address_reg [NCH];
  logic [31:0]           destination_address_reg [NCH];
  logic [DMAQ_CNT_W-1:0] tcr [NCH];
  logic [3:0]            ctrl [NCH];
  logic [1:0]            pend [NCH];
  logic [NCH-1:0]        pend_nz, elig, qclr, qinc, done_v, te_v, ie_v;
  dmaq_state_t           state;
  logic [2:0]            cur, pick;
  logic                  any_elig, ae_hit, ae_set;
  logic [7:0]            bcnt;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic        aw_h, w_h, wr_do, wr_ok, rd_ok;
  logic [31:0] rd_mux;
  wire         aw_ch = aw_q[11:7] == CH_REGION;
  wire  [2:0]  aw_n  = aw_q[6:4];
  wire  [1:0]  aw_r  = aw_q[3:2];
  wire         ar_ch = s_axi_araddr[11:7] == CH_REGION;
  wire  [2:0]  ar_n  = s_axi_araddr[6:4];
  wire         ar_go = s_axi_arvalid & s_axi_arready;

  assign wr_do = aw_h & w_h & ~s_axi_bvalid;
  assign wr_ok = aw_ch | (aw_q == OFF_OPER);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0; w_h <= 1'b0; aw_q <= 12'h000; w_q <= 32'h0000_0000;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_h <= 1'b1; aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_h <= 1'b1; w_q <= s_axi_wdata;
      end
      s_axi_awready <= ~aw_h & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_h & ~(s_axi_wvalid & s_axi_wready);
      if (wr_do) begin
        aw_h <= 1'b0; w_h <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    if (ar_ch) begin
      case (s_axi_araddr[3:2])
        CH_SAR:  rd_mux = source_address_reg[ar_n];
        CH_DAR:  rd_mux = destination_address_reg[ar_n];
        CH_TCR:  rd_mux = {{(32-DMAQ_CNT_W){1'b0}}, tcr[ar_n]};
        default: rd_mux = {28'h000_0000, ctrl[ar_n]};
      endcase
    end else if (s_axi_araddr == OFF_OPER) begin
      rd_mux[OPER_DME] = master_enable_bit;   rd_mux[OPER_NMI_FLAG] = nmi_flag; rd_mux[OPER_AE] = ae;
      rd_mux[OPER_SEL8] = sel8; rd_mux[OPER_ODT] = odt;
    end else if (s_axi_araddr == OFF_EVT) begin
      rd_mux = {19'h0_0000, irq, irq_code};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_go;
      if (ar_go) begin
        s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operation register and error flags
  // ----------------------------------------------------------------
  wire oper_wr = wr_do & (aw_q == OFF_OPER) & s_axi_wstrb[0];
  wire oper_rd = ar_go & (s_axi_araddr == OFF_OPER);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_enable_bit <= 1'b0; sel8 <= 1'b0; odt <= 1'b0;
      nmi_flag <= 1'b0; ae <= 1'b0; ae_arm <= 1'b0; nmi_flag_arm <= 1'b0;
    end else begin
      if (oper_wr) master_enable_bit <= w_q[OPER_DME];
      if (wr_do & (aw_q == OFF_OPER) & s_axi_wstrb[1]) begin
        sel8 <= w_q[OPER_SEL8]; odt <= w_q[OPER_ODT];
      end
      if (oper_rd) begin
        ae_arm <= ae; nmi_flag_arm <= nmi_flag;
      end
      if (nmi_in) nmi_flag <= 1'b1;
      else if (oper_wr & nmi_flag_arm & ~w_q[OPER_NMI_FLAG]) nmi_flag <= 1'b0;
      if (ae_set) ae <= 1'b1;
      else if (oper_wr & ae_arm & ~w_q[OPER_AE]) ae <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Request word decode
  // ----------------------------------------------------------------
  // field layout via struct
  wire req_go  = req_valid & req_ready;
  wire clr_all = req_word.chan_id == RQ_ID_CLR & req_word.mode == RQ_MD_ALL
                 & req_word.size == RQ_SZ_ALL;
  wire one_cmd = req_word.chan_id == RQ_ID_CLR & req_word.mode == RQ_MD_ONE;
  wire clr_one = one_cmd & sel8;
  wire [2:0] req_ch = {sel8 & (req_word.size == RQ_SZ_HI), req_word.chan_id};
  wire [3:0] nib_m1 = req_word.count_hi - 4'h1;

  always_comb begin
    qclr = '0;
    qinc = '0;
    if (req_go) begin
      if (clr_all) qclr = '1;
      else if (clr_one && req_word.count_hi != 4'h0 && nib_m1 < 4'(NCH))
        qclr[nib_m1[2:0]] = 1'b1;
      else if (!one_cmd) qinc[req_ch] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) req_ready <= 1'b0;
    else          req_ready <= odt;
  end

  // ----------------------------------------------------------------
  // Channel registers and queues
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire sel = wr_do & aw_ch & (aw_n == 3'(g));
      assign pend_nz[g] = pend[g] != 2'h0;
      assign te_v[g]    = ctrl[g][CTRL_TE];
      assign ie_v[g]    = ctrl[g][CTRL_IE];
      assign elig[g]    = pend_nz[g] & master_enable_bit & ctrl[g][CTRL_DE] & ~te_v[g] & ~nmi_flag & ~ae;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          source_address_reg[g] <= 32'h0000_0000; destination_address_reg[g] <= 32'h0000_0000;
          tcr[g] <= '0; ctrl[g] <= 4'h0; pend[g] <= 2'h0;
        end else begin
          if (qclr[g]) pend[g] <= 2'h0;
          else if (qinc[g] & ~done_v[g] & pend[g] != 2'(QMAX)) pend[g] <= pend[g] + 2'h1;
          else if (done_v[g] & ~qinc[g]) pend[g] <= pend[g] - 2'h1;
          if (done_v[g]) begin
            source_address_reg[g] <= source_address_reg[g] + ADDR_STEP;
            destination_address_reg[g] <= destination_address_reg[g] + ADDR_STEP;
            tcr[g] <= tcr[g] - 1'b1;
            if (tcr[g] == DMAQ_CNT_W'(1)) ctrl[g][CTRL_TE] <= 1'b1;
          end
          if (sel && aw_r == CH_SAR) source_address_reg[g] <= w_q;
          if (sel && aw_r == CH_DAR) destination_address_reg[g] <= w_q;
          if (sel && aw_r == CH_TCR) tcr[g] <= w_q[DMAQ_CNT_W-1:0];
          if (sel && aw_r == CH_CTRL) ctrl[g] <= w_q[3:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  always_comb begin
    pick = 3'h0;
    any_elig = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = 3'(i);
        any_elig = 1'b1;
      end
    end
  end

  assign ae_hit = ctrl[pick][CTRL_SAM] & (source_address_reg[pick][31:24] == PERIPH_TOP);
  assign ae_set = state == ST_IDLE & any_elig & ae_hit;
  wire   b_end  = state == ST_BUSY & bcnt == 8'(BUS_CYC - 1);
  assign done_v = b_end ? (NCH'(1) << cur) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE; cur <= 3'h0; bcnt <= 8'h00;
      transfer_ack <= 1'b0; ack_channel <= 3'h0; bus_addr <= 32'h0000_0000;
    end else begin
      transfer_ack <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (any_elig & ~ae_hit) begin
            state <= ST_BUSY; cur <= pick; bcnt <= 8'h00;
            transfer_ack <= 1'b1; ack_channel <= pick; bus_addr <= source_address_reg[pick];
          end
        end
        ST_BUSY: begin
          bcnt <= bcnt + 8'h01;
          if (b_end) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and event code
  // ----------------------------------------------------------------
  logic [11:0] next_code;
  logic        next_irq;
  always_comb begin
    next_code = 12'h000;
    next_irq  = 1'b0;
    if (ae) begin
      next_code = EVT_AE;
      next_irq  = 1'b1;
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (te_v[i] & ie_v[i]) begin
        next_code = EVT_CODE[i];
        next_irq  = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0; irq_code <= 12'h000;
    end else begin
      irq <= next_irq; irq_code <= next_code;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_clr_all;
    req_go && clr_all |=> pend_nz == '0;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("clear-all left a queue");

  property p_clr_ch2;
    req_go && clr_one && req_word.count_hi == 4'h3 |=> !pend_nz[2];
  endproperty
  a_clr_ch2: assert property (p_clr_ch2) else $error("channel clear missed");

  property p_no_sel8;
    req_go && one_cmd && !sel8 |=> (pend_nz & ~$past(pend_nz)) == '0;
  endproperty
  a_no_sel8: assert property (p_no_sel8) else $error("mode 11 acted without 8ch");

  property p_start_en;
    transfer_ack |-> $past(master_enable_bit) && $past(ctrl[pick][CTRL_DE]) && ack_channel == $past(pick);
  endproperty
  a_start_en: assert property (p_start_en) else $error("start without enables");

  sequence s_end_nodme;
    b_end && !master_enable_bit && !$rose(master_enable_bit);
  endsequence
  property p_dme_stop;
    s_end_nodme ##1 !master_enable_bit |-> state == ST_IDLE && !transfer_ack;
  endproperty
  a_dme_stop: assert property (p_dme_stop) else $error("ran on after disable");

  property p_nmi;
    nmi_in |=> nmi_flag;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi flag not set");

  property p_nmi_hold;
    nmi_flag && state == ST_IDLE && !wr_do |=> $stable(tcr[0]) && $stable(source_address_reg[0]);
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("count moved under nmi");

  property p_ae_irq;
    $rose(ae) |-> ##[1:2] irq ##0 !$rose(state == ST_BUSY);
  endproperty
  a_ae_irq: assert property (p_ae_irq) else $error("address error not raised");

  sequence s_ch0_int;
    te_v[0] && ie_v[0];
  endsequence
  property p_code0;
    s_ch0_int ##1 s_ch0_int |-> irq && irq_code == EVT_CODE[0];
  endproperty
  a_code0: assert property (p_code0) else $error("wrong channel 0 code");
endmodule : dmaq_ctrl
`default_nettype wire

/* bench/dmaq_requester.sv */
`timescale 1ns/100ps
`default_nettype none
module dmaq_requester (
  // Clock
  input  wire logic           aclk,
  // Mode seen by the requester
  input  wire logic           eight_channel_select,
  // Request word link
  output logic                req_valid,
  output dmaq_pkg::dmaq_req_t req_word,
  input  wire logic           req_ready
);
  import dmaq_pkg::*;

  initial begin
    req_valid = 1'b0;
    req_word  = '0;
  end

  // -----------------------------------------------------------
  // Word sender
  // -----------------------------------------------------------
  task automatic send(input logic [2:0] sz, input logic [1:0] id, input logic [1:0] md,
                      input logic [3:0] nib, input logic [19:0] rest);
    dmaq_req_t w;
    w = '{size: sz, rsv: 1'b0, chan_id: id, mode: md, count_hi: nib, rest: rest};
    // no per-channel clear in four-channel mode
    if (md == 2'h3 && !eight_channel_select) return;
    @(posedge aclk);
    req_valid <= 1'b1;
    req_word  <= w;
    do @(posedge aclk); while (req_ready !== 1'b1);
    // Released word is inverted so stale data cannot pass for a request
    req_valid <= 1'b0;
    req_word  <= ~w;
  endtask : send
endmodule : dmaq_requester
`default_nettype wire

/* bench/dma_queue_clear_and_completion_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module dma_queue_clear_and_completion_bench;
  import dmaq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, nmi_in = 1'b0, sel8 = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0, base, irq_code;
  logic [31:0] wdata = '0, rdata, bus_addr, source_address_reg;
  logic awready, wready, bvalid, arready, rvalid, req_valid, req_ready, transfer_ack, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] ack_channel;
  dmaq_req_t req_word;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [2:0] aq[$];
  int mismatches = 0, comparisons = 0, seed = 97;
  localparam logic [11:0] CODE [8] = '{12'h640, 12'h660, 12'h680, 12'h6A0,
                                       12'h780, 12'h7A0, 12'h7C0, 12'h7E0};

  always #10 aclk = ~aclk;

  dmaq_ctrl dmaq_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .req_valid(req_valid), .req_word(req_word),
    .req_ready(req_ready), .nmi_in(nmi_in), .transfer_ack(transfer_ack),
    .ack_channel(ack_channel), .bus_addr(bus_addr), .irq(irq), .irq_code(irq_code));

  dmaq_requester dmaq_requester_inst (.aclk(aclk), .eight_channel_select(sel8),
    .req_valid(req_valid), .req_word(req_word), .req_ready(req_ready));

  // -----------------------------------------------------------
  // Bus tasks and verdict
  // -----------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) aw_ok = 1'b1;
      if (wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!(aw_ok && w_ok));
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  task automatic rq_ch(input int k);
    dmaq_requester_inst.send(k >= 4 ? 3'h5 : 3'h2, 2'(k), 2'h0, 4'h0, 20'($random(seed)));
  endtask : rq_ch

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // -----------------------------------------------------------
  // Result watcher
  // -----------------------------------------------------------
  always @(posedge aclk) begin : watch
    logic [33:0] e;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = rq.pop_front();
      `CHK("rresp", e[33:32], rresp)
      if (e[33:32] == RESP_OKAY) `CHK("rdata", e[31:0], rdata)
    end
    if (bvalid === 1'b1 && bready === 1'b1) `CHK("bresp", bq.pop_front(), bresp)
    if (transfer_ack === 1'b1) begin
      if (aq.size() == 0) `CHK("transfer_ack", 1'b0, 1'b1)
      else `CHK("ack_channel", aq.pop_front(), ack_channel)
    end
  end

  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h0F0, 32'h0, RESP_SLVERR);
    wr(12'h0F0, 32'h0, RESP_SLVERR);
    wr(12'h000, 32'hC007);
    rd(12'h000, 32'hC001);
    sel8 <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      base = 12'h100 + 12'(k * 16);
      // sources stay outside the peripheral space (top byte FF)
      source_address_reg = 32'($random(seed)) & 32'h00FF_FFFC;
      wr(base, source_address_reg);
      wr(base + 12'h4, ~source_address_reg & 32'h00FF_FFFC);
      wr(base + 12'h8, 32'h1);
      rq_ch(k);
      dmaq_requester_inst.send(3'h0, 2'h0, 2'h3, 4'(k + 1), 20'($random(seed)));
      wr(base + 12'hC, 32'h5);
      repeat (12) @(posedge aclk);
      rd(base + 12'h8, 32'h1);
      aq.push_back(3'(k));
      rq_ch(k);
      repeat (12) @(posedge aclk);
      rd(base + 12'h8, 32'h0);
      rd(base, source_address_reg + 32'h4);
      rd(base + 12'hC, 32'h7);
      rd(12'h004, {19'h0, 1'b1, CODE[k]});
      wr(base + 12'hC, 32'h0);
      wr(base + 12'h8, 32'h0);
      rd(12'h004, 32'h0);
    end
    $display("selective clear test done");
    wr(12'h000, 32'h8001);
    sel8 <= 1'b0;
    wr(12'h108, 32'h1);
    wr(12'h138, 32'h1);
    rq_ch(0);
    rq_ch(3);
    dmaq_requester_inst.send(3'h6, 2'h0, 2'h2, 4'($random(seed)), 20'($random(seed)));
    wr(12'h10C, 32'h5);
    wr(12'h13C, 32'h5);
    repeat (12) @(posedge aclk);
    rd(12'h108, 32'h1);
    rd(12'h138, 32'h1);
    aq.push_back(3'h0);
    aq.push_back(3'h3);
    rq_ch(0);
    rq_ch(3);
    repeat (20) @(posedge aclk);
    rd(12'h004, {19'h0, 1'b1, CODE[0]});
    wr(12'h10C, 32'h0);
    rd(12'h004, {19'h0, 1'b1, CODE[3]});
    wr(12'h13C, 32'h0);
    $display("full clear and priority test done");
    @(posedge aclk);
    nmi_in <= 1'b1;
    @(posedge aclk);
    nmi_in <= 1'b0;
    rd(12'h000, 32'h8003);
    wr(12'h128, 32'h2);
    wr(12'h12C, 32'h1);
    rq_ch(2);
    repeat (12) @(posedge aclk);
    rd(12'h128, 32'h2);
    aq.push_back(3'h2);
    rd(12'h000, 32'h8003);
    wr(12'h000, 32'h8001);
    rd(12'h000, 32'h8001);
    repeat (12) @(posedge aclk);
    rd(12'h128, 32'h1);
    $display("nmi test done");
    wr(12'h12C, 32'h0);
    wr(12'h128, 32'h3);
    rq_ch(2);
    rq_ch(2);
    aq.push_back(3'h2);
    wr(12'h12C, 32'h1);
    wr(12'h000, 32'h8000);
    repeat (12) @(posedge aclk);
    rd(12'h128, 32'h2);
    wr(12'h12C, 32'h0);
    $display("master disable test done");
    wr(12'h118, 32'h1);
    wr(12'h110, 32'hFF00_0010);
    wr(12'h11C, 32'h9);
    wr(12'h000, 32'h8001);
    rq_ch(1);
    repeat (12) @(posedge aclk);
    rd(12'h000, 32'h8005);
    rd(12'h004, {19'h0, 1'b1, 12'h6C0});
    rd(12'h118, 32'h1);
    wr(12'h11C, 32'h0);
    wr(12'h000, 32'h8001);
    rd(12'h000, 32'h8001);
    $display("address error test done");
    repeat (4) @(posedge aclk);
    `CHK("acks outstanding", 0, aq.size())
    give_verdict();
  end
endmodule : dma_queue_clear_and_completion_bench
`default_nettype wire
